// ### rtl/irq_handler_pkg.sv
// Package: constants, register map and carrier types of the interrupt handler
package irq_handler_pkg;
    localparam int NUM_SRC   = 19;
    localparam int NUM_FLAGS = 32;
    localparam int SRC_W     = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_PRIORITY = 8'h04;
    localparam logic [7:0] OFS_EXT_EN1  = 8'h08;
    localparam logic [7:0] OFS_EXT_EN2  = 8'h0C;
    localparam logic [7:0] OFS_EXT_PR1  = 8'h10;
    localparam logic [7:0] OFS_EXT_PR2  = 8'h14;
    localparam logic [7:0] OFS_PENDING  = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1C;

    // Field positions and reset values
    localparam int         GLOBAL_EN_BIT  = 7;
    localparam int         EXT_EN1_BASE   = 7;
    localparam int         EXT_EN2_BASE   = 15;
    localparam logic [7:0] ENABLE_RST     = 8'h00;
    localparam logic [7:0] PRIORITY_RST   = 8'h00;
    localparam logic [7:0] PRIORITY_RD1   = 8'h80;
    localparam int         FLAG_SUPPLY    = 24;
    localparam int         FLAG_PORTMATCH = 25;

    // Writable flags; supply warning and port match follow their inputs
    localparam logic [31:0] FLAG_WR_MASK = 32'h7CFF_FFFF;
    // Flags cleared by hardware on vectoring: ext0, timer0, ext1, timer1
    localparam logic [31:0] HWCLR_MASK   = 32'h0000_000F;

    // Flags that belong to each source, OR-ed into one request
    localparam logic [31:0] SRC_MASK [NUM_SRC] = '{
        32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
        32'h0000_0030, 32'h0000_00C0, 32'h0000_0F00, 32'h0000_1000,
        32'h0000_2000, 32'h0000_4000, 32'h0000_8000, 32'h0003_0000,
        32'h000C_0000, 32'h0030_0000, 32'h00C0_0000, 32'h0100_0000,
        32'h0200_0000, 32'h0400_0000, 32'h7800_0000};

    // Vectors
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTOR_BASE  = 16'h0003;
    localparam int          VECTOR_STEP  = 8;

    // Latency figures in system clocks
    localparam int DETECT_CYCLES = 1;
    localparam int INSTR_CYCLES  = 1;
    localparam int LONG_CALL_CYCLES  = 5;
    localparam int RETURN_FROM_IRQ_CYCLES   = 5;
    localparam int DIV_CYCLES    = 8;
    localparam int MIN_RESPONSE  = DETECT_CYCLES + INSTR_CYCLES + LONG_CALL_CYCLES;
    localparam int MAX_RESPONSE  = DETECT_CYCLES + RETURN_FROM_IRQ_CYCLES + DIV_CYCLES + LONG_CALL_CYCLES;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_CALL  = 2'b11,
        ST_LONG_CALL = 2'b10
    } irq_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
endpackage

// ### rtl/irq_handler.sv
// Two-level vectored interrupt handler with AXI4-Lite register access
//
// Function
// - Source event sets pending flag regardless of enables
// - Request needs global and source enable
// - Finish current instruction, then force long call
// - Return ends service level; CPU resumes program
// - Hardware clears ext and timer0/1 flags on vectoring
// - Flag still set after return re-requests
// - Global enable bit 7 blocks all sources
// - Disabled requests stay pending until enabled
// - Software write of one acts as event
// - Two levels; high preempts low, never preempted
// - Priority bits reset to low
// - Higher level first, then fixed order
// - Sample every cycle; minimum response seven cycles
// - One instruction runs after return before call
// - Worst case response nineteen clocks
// - Equal or lower level waits for return
// - Vector is 0x0003 plus eight per order
// - Fixed source order ext0 through SPI1
// - Read-only supply flag not software clearable
`timescale 1ns/1ps
module irq_handler (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      resetn_i,
    // Register bus
    input  wire irq_handler_pkg::axil_req_t axil_req_i,
    output irq_handler_pkg::axil_rsp_t      axil_rsp_o,
    // Interrupt sources
    input  wire logic [31:0]               flag_event_i,
    input  wire logic                      ext_irq_pin_0_i,
    input  wire logic                      ext_irq_pin_1_i,
    input  wire logic                      supply_warn_i,
    input  wire logic                      port_match_i,
    // CPU sequencer
    input  wire logic                      instr_done_i,
    input  wire logic                      return_from_irq_done_i,
    input  wire logic                      long_call_ack_i,
    output logic                           long_call_req_o,
    output logic [15:0]                    long_call_vector_o,
    output logic [1:0]                     in_service_o
);
    import irq_handler_pkg::*;

    // Registers
    logic [7:0]         enable_r;
    logic [7:0]         priority_r;
    logic [7:0]         ext_en1_r;
    logic [7:0]         ext_en2_r;
    logic [7:0]         ext_pr1_r;
    logic [7:0]         ext_pr2_r;
    logic [31:0]        pending_r;
    logic [31:0]        pending_nxt;
    logic               ins_low_r;
    logic               ins_high_r;
    logic               skip_r;
    irq_state_t         state_r;
    irq_state_t         state_nxt;
    logic [2:0]         long_call_cnt_r;
    logic               win_valid_r;
    logic               win_high_r;
    logic [SRC_W-1:0]   win_src_r;
    logic [SRC_W-1:0]   act_src_r;
    logic               act_high_r;
    logic [15:0]        vector_r;
    logic [1:0]         pin0_sync_r;
    logic [1:0]         pin1_sync_r;
    logic               pin0_prev_r;
    logic               pin1_prev_r;

    // Bus slave state
    logic               aw_held_r;
    logic               w_held_r;
    logic [7:0]         aw_addr_r;
    logic [31:0]        w_data_r;
    logic [3:0]         w_strb_r;
    logic               bvalid_r;
    logic               rvalid_r;
    logic [1:0]         bresp_r;
    logic [1:0]         rresp_r;
    logic [31:0]        rdata_r;

    // Write channel: address and data taken in either order
    wire aw_take  = axil_req_i.awvalid && !aw_held_r && !bvalid_r;
    wire w_take   = axil_req_i.wvalid && !w_held_r && !bvalid_r;
    wire aw_have  = aw_held_r || aw_take;
    wire w_have   = w_held_r || w_take;
    wire wr_fire  = aw_have && w_have && !bvalid_r;
    wire [7:0]  wr_addr = aw_held_r ? aw_addr_r : axil_req_i.awaddr;
    wire [31:0] wr_data = w_held_r ? w_data_r : axil_req_i.wdata;
    wire [3:0]  wr_strb = w_held_r ? w_strb_r : axil_req_i.wstrb;
    wire [31:0] wr_bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                            {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_lane0 = wr_fire && wr_strb[0];

    wire wr_en   = wr_lane0 && (wr_addr == OFS_ENABLE);
    wire wr_pr   = wr_lane0 && (wr_addr == OFS_PRIORITY);
    wire wr_een1 = wr_lane0 && (wr_addr == OFS_EXT_EN1);
    wire wr_een2 = wr_lane0 && (wr_addr == OFS_EXT_EN2);
    wire wr_epr1 = wr_lane0 && (wr_addr == OFS_EXT_PR1);
    wire wr_epr2 = wr_lane0 && (wr_addr == OFS_EXT_PR2);
    wire wr_pend = wr_fire && (wr_addr == OFS_PENDING);
    wire wr_map  = (wr_addr[1:0] == 2'b00) && (wr_addr <= OFS_STATUS);

    // Read channel
    wire rd_take = axil_req_i.arvalid && !rvalid_r;
    wire [7:0] rd_addr = axil_req_i.araddr;
    wire rd_map  = (rd_addr[1:0] == 2'b00) && (rd_addr <= OFS_STATUS);

    // Per-source enables and levels
    wire [NUM_SRC-1:0] src_en = {ext_en2_r[3:0], ext_en1_r, enable_r[6:0]};
    wire [NUM_SRC-1:0] src_hi = {ext_pr2_r[3:0], ext_pr1_r, priority_r[6:0]};
    wire               global_en = enable_r[GLOBAL_EN_BIT];

    // A source requests while any one of its flags is set
    logic [NUM_SRC-1:0] src_req;
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            src_req[s] = |(pending_r & SRC_MASK[s]);
        end
    end

    // Gated requests; undeclared requests simply stay pending
    wire [NUM_SRC-1:0] req_on = src_req & src_en & {NUM_SRC{global_en}};
    wire [NUM_SRC-1:0] req_hi = req_on & src_hi;

    // Fixed-order arbitration; lowest order wins within a level
    logic             arb_valid, arb_high;
    logic [SRC_W-1:0] arb_src;
    always_comb begin
        arb_valid = 1'b0;
        arb_high  = 1'b0;
        arb_src   = '0;
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (req_on[s] && !(|req_hi && !src_hi[s])) begin
                arb_valid = 1'b1;
                arb_high  = src_hi[s];
                arb_src   = SRC_W'(s);
            end
        end
    end

    // Preemption: high beats low in service, nothing beats high
    wire eligible = win_valid_r && !ins_high_r && (win_high_r || !ins_low_r);
    // After a return one ordinary instruction must finish before the next call
    wire boundary = instr_done_i && !skip_r;

    // Vector steps by a fixed stride per source order
    wire [15:0] win_vector = VECTOR_BASE + 16'(VECTOR_STEP) * 16'(win_src_r);
    wire        call_taken = (state_r == ST_CALL) && long_call_ack_i;
    wire [31:0] hw_clear   = call_taken ? (SRC_MASK[act_src_r] & HWCLR_MASK) : 32'h0;

    // External pins: synchronise, then set on falling edge
    wire pin0_fall = pin0_prev_r && !pin0_sync_r[1];
    wire pin1_fall = pin1_prev_r && !pin1_sync_r[1];
    wire [31:0] hw_set = flag_event_i | {30'h0, 1'b0, pin0_fall} | {29'h0, pin1_fall, 2'b00};

    // Set wins over both hardware and software clear
    always_comb begin
        pending_nxt = pending_r;
        if (wr_pend) begin
            pending_nxt = (pending_r & ~(wr_bmask & FLAG_WR_MASK))
                        | (wr_data & wr_bmask & FLAG_WR_MASK);
        end
        pending_nxt = (pending_nxt & ~hw_clear) | (hw_set & FLAG_WR_MASK);
        // Read-only flags are live copies, so software writes never reach them
        pending_nxt[FLAG_SUPPLY]    = supply_warn_i;
        pending_nxt[FLAG_PORTMATCH] = port_match_i;
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (eligible) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!eligible) begin
                    state_nxt = ST_IDLE;
                end else if (boundary) begin
                    state_nxt = ST_CALL;
                end
            end
            ST_CALL: begin
                if (long_call_ack_i) begin
                    state_nxt = ST_LONG_CALL;
                end
            end
            ST_LONG_CALL: begin
                if (long_call_cnt_r == 3'(LONG_CALL_CYCLES - 1)) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            // Park at the idle high level so no false fall follows reset
            pin0_sync_r <= 2'b11;
            pin1_sync_r <= 2'b11;
            pin0_prev_r <= 1'b1;
            pin1_prev_r <= 1'b1;
        end else begin
            pin0_sync_r <= {pin0_sync_r[0], ext_irq_pin_0_i};
            pin1_sync_r <= {pin1_sync_r[0], ext_irq_pin_1_i};
            pin0_prev_r <= pin0_sync_r[1];
            pin1_prev_r <= pin1_sync_r[1];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            enable_r   <= ENABLE_RST;
            priority_r <= PRIORITY_RST;
            ext_en1_r  <= ENABLE_RST;
            ext_en2_r  <= ENABLE_RST;
            ext_pr1_r  <= PRIORITY_RST;
            ext_pr2_r  <= PRIORITY_RST;
            pending_r  <= '0;
        end else begin
            if (wr_en)   enable_r   <= wr_data[7:0];
            if (wr_pr)   priority_r <= wr_data[7:0];
            if (wr_een1) ext_en1_r  <= wr_data[7:0];
            if (wr_een2) ext_en2_r  <= wr_data[7:0];
            if (wr_epr1) ext_pr1_r  <= wr_data[7:0];
            if (wr_epr2) ext_pr2_r  <= wr_data[7:0];
            pending_r <= pending_nxt;
        end
    end

    // Sample and decode every cycle
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            win_valid_r <= 1'b0;
            win_high_r  <= 1'b0;
            win_src_r   <= '0;
        end else begin
            win_valid_r <= arb_valid;
            win_high_r  <= arb_high;
            win_src_r   <= arb_src;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_r     <= ST_IDLE;
            long_call_cnt_r <= '0;
            act_src_r   <= '0;
            act_high_r  <= 1'b0;
            vector_r    <= RESET_VECTOR;
        end else begin
            state_r <= state_nxt;
            // Counts out the long call; no new arbitration acts meanwhile
            long_call_cnt_r <= (state_r == ST_LONG_CALL) ? long_call_cnt_r + 3'd1 : 3'd0;
            if (state_r == ST_ARMED && eligible && boundary) begin
                act_src_r  <= win_src_r;
                act_high_r <= win_high_r;
                vector_r   <= win_vector;
            end
        end
    end

    // Nesting: a return closes the innermost level
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ins_low_r  <= 1'b0;
            ins_high_r <= 1'b0;
            skip_r     <= 1'b0;
        end else begin
            if (call_taken) begin
                if (act_high_r) ins_high_r <= 1'b1;
                else            ins_low_r  <= 1'b1;
            end else if (return_from_irq_done_i) begin
                if (ins_high_r) ins_high_r <= 1'b0;
                else            ins_low_r  <= 1'b0;
            end
            // A return always lets one more instruction run
            if (return_from_irq_done_i)       skip_r <= 1'b1;
            else if (instr_done_i) skip_r <= 1'b0;
        end
    end

    // The level of the call in flight is latched with its vector: the winner
    // registers keep decoding while the call waits for its acknowledge.

    // Bus slave
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'b00;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_map ? 2'b00 : 2'b10;
            end else begin
                if (aw_take) begin
                    aw_held_r <= 1'b1;
                    aw_addr_r <= axil_req_i.awaddr;
                end
                if (w_take) begin
                    w_held_r <= 1'b1;
                    w_data_r <= axil_req_i.wdata;
                    w_strb_r <= axil_req_i.wstrb;
                end
                // Response stands until the master takes it
                if (bvalid_r && axil_req_i.bready) bvalid_r <= 1'b0;
            end
        end
    end

    // Unmapped addresses read as zero
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            OFS_ENABLE:   rd_mux = {24'h0, enable_r};
            OFS_PRIORITY: rd_mux = {24'h0, priority_r | PRIORITY_RD1};
            OFS_EXT_EN1:  rd_mux = {24'h0, ext_en1_r};
            OFS_EXT_EN2:  rd_mux = {24'h0, ext_en2_r};
            OFS_EXT_PR1:  rd_mux = {24'h0, ext_pr1_r};
            OFS_EXT_PR2:  rd_mux = {24'h0, ext_pr2_r};
            OFS_PENDING:  rd_mux = pending_r;
            OFS_STATUS:   rd_mux = {15'h0, win_valid_r, 3'h0, act_src_r,
                                    4'h0, state_r, ins_high_r, ins_low_r};
            default:      rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= 2'b00;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_map ? 2'b00 : 2'b10;
        end else if (rvalid_r && axil_req_i.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Ready drops while a half is held or a response waits
    assign axil_rsp_o.awready = !aw_held_r && !bvalid_r;
    assign axil_rsp_o.wready  = !w_held_r && !bvalid_r;
    assign axil_rsp_o.bvalid  = bvalid_r;
    assign axil_rsp_o.bresp   = bresp_r;
    assign axil_rsp_o.arready = !rvalid_r;
    assign axil_rsp_o.rvalid  = rvalid_r;
    assign axil_rsp_o.rdata   = rdata_r;
    assign axil_rsp_o.rresp   = rresp_r;

    assign long_call_req_o    = (state_r == ST_CALL);
    assign long_call_vector_o = vector_r;
    assign in_service_o       = {ins_high_r, ins_low_r};
endmodule // irq_handler

// ### verif/irq_handler_props.sv
// Port-level assertions for the interrupt handler
`timescale 1ns/1ps
module irq_handler_props (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        resetn_i,
    // CPU sequencer
    input wire logic        instr_done_i,
    input wire logic        return_from_irq_done_i,
    input wire logic        long_call_ack_i,
    input wire logic        long_call_req_o,
    input wire logic [15:0] long_call_vector_o,
    input wire logic [1:0]  in_service_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_call_after_instr: assert property ($rose(long_call_req_o) |-> $past(instr_done_i))
        else $error("call raised without a completed instruction");
    a_req_holds: assert property (long_call_req_o && !long_call_ack_i |=>
        long_call_req_o && $stable(long_call_vector_o))
        else $error("call request or vector moved before ack");
    a_vector_form: assert property (long_call_req_o |->
        long_call_vector_o[2:0] == 3'h3 && long_call_vector_o <= 16'h0093)
        else $error("vector outside the table");
    a_long_call_gap: assert property (long_call_req_o && long_call_ack_i |=>
        !long_call_req_o [*5])
        else $error("new call inside the long call");
    a_ack_service: assert property (long_call_req_o && long_call_ack_i |=>
        in_service_o != 2'b00)
        else $error("no level in service after ack");
    a_high_blocks: assert property ($rose(long_call_req_o) |-> !in_service_o[1])
        else $error("call raised during high level service");
    a_return_from_irq_high: assert property (return_from_irq_done_i && in_service_o == 2'b11 |=>
        in_service_o == 2'b01)
        else $error("return did not end the high level");
    a_return_from_irq_skip: assert property (return_from_irq_done_i |-> ##2 !$rose(long_call_req_o))
        else $error("call without the instruction after return");
    a_reset_idle: assert property ($rose(resetn_i) |-> !long_call_req_o &&
        in_service_o == 2'b00 && long_call_vector_o == 16'h0000)
        else $error("state not cleared by reset");
endmodule // irq_handler_props

// ### verif/cpu_model.sv
// Behavioural CPU sequencer on the far side of the call handshake
`timescale 1ns/1ps
module cpu_model (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // Call handshake
    input  wire logic long_call_req_i,
    output logic      instr_done_o,
    output logic      return_from_irq_done_o,
    output logic      long_call_ack_o
);
    int ack_wait = 0;
    int cnt_r    = 0;

    initial begin
        instr_done_o    = 1'b0;
        return_from_irq_done_o     = 1'b0;
        long_call_ack_o = 1'b0;
    end

    // Slow answers delay the start of the call by ack_wait cycles
    always @(posedge clock_i) begin
        if (!resetn_i || !long_call_req_i || long_call_ack_o) begin
            long_call_ack_o <= 1'b0;
            cnt_r           <= 0;
        end else if (cnt_r >= ack_wait) begin
            long_call_ack_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end

    // Trailing idle edge keeps back-to-back calls from colliding
    task automatic step(input int n);
        instr_done_o <= 1'b1;
        repeat (n) @(posedge clock_i);
        instr_done_o <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic ret();
        return_from_irq_done_o <= 1'b1;
        @(posedge clock_i);
        return_from_irq_done_o <= 1'b0;
        @(posedge clock_i);
    endtask
endmodule // cpu_model

// ### verif/testbench.sv
// Self-checking bench for the interrupt handler
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
    import irq_handler_pkg::*;
    logic        clock_i;
    logic        resetn_i;
    axil_req_t   axil_req_i;
    axil_rsp_t   axil_rsp_o;
    logic [31:0] flag_event_i;
    logic        ext_irq_pin_0_i;
    logic        ext_irq_pin_1_i;
    logic        supply_warn_i;
    logic        port_match_i;
    logic        instr_done_i;
    logic        return_from_irq_done_i;
    logic        long_call_ack_i;
    logic        long_call_req_o;
    logic [15:0] long_call_vector_o;
    logic [1:0]  in_service_o;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc       = 0;

    irq_handler irq_handler_i (.clock_i, .resetn_i, .axil_req_i, .axil_rsp_o, .flag_event_i,
        .ext_irq_pin_0_i, .ext_irq_pin_1_i, .supply_warn_i, .port_match_i, .instr_done_i,
        .return_from_irq_done_i, .long_call_ack_i, .long_call_req_o, .long_call_vector_o, .in_service_o);
    cpu_model cpu_model_i (.clock_i, .resetn_i, .long_call_req_i(long_call_req_o),
        .instr_done_o(instr_done_i), .return_from_irq_done_o(return_from_irq_done_i),
        .long_call_ack_o(long_call_ack_i));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axil_req_i <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
                        bready: 1'b1, default: '0};
        forever begin
            @(posedge clock_i);
            if (axil_rsp_o.bvalid) break;
            if (axil_rsp_o.awready) axil_req_i.awvalid <= 1'b0;
            if (axil_rsp_o.wready) axil_req_i.wvalid <= 1'b0;
        end
        rs = axil_rsp_o.bresp;
        axil_req_i <= '0;
        @(posedge clock_i);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        axil_req_i <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        forever begin
            @(posedge clock_i);
            if (axil_rsp_o.rvalid) break;
            if (axil_rsp_o.arready) axil_req_i.arvalid <= 1'b0;
        end
        rd = axil_rsp_o.rdata;
        rs = axil_rsp_o.rresp;
        axil_req_i <= '0;
        @(posedge clock_i);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd_reg(a);
        `CHK(rd, e)
    endtask

    // Steps the CPU until a call shows, then lets the long call run out
    task automatic call(input logic [15:0] v, input logic [1:0] s);
        for (int n = 0; n < 30 && long_call_req_o !== 1'b1; n++) cpu_model_i.step(1);
        `CHK(long_call_vector_o, v)
        for (int n = 0; n < 30 && long_call_req_o !== 1'b0; n++) @(posedge clock_i);
        repeat (6) @(posedge clock_i);
        `CHK(in_service_o, s)
    endtask

    task automatic quiet(input int k);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < k; n++) begin
            cpu_model_i.step(1);
            seen = seen | long_call_req_o;
        end
        `CHK(seen, 1'b0)
    endtask

    task automatic t_regs();
        rchk(OFS_ENABLE, 32'h0000_0000);
        rchk(OFS_PRIORITY, 32'h0000_0080);
        rchk(OFS_EXT_PR1, 32'h0000_0000);
        rchk(OFS_PENDING, 32'h0000_0000);
        rchk(OFS_STATUS, 32'h0000_0000);
        rd_reg(8'h20);
        `CHK({rs, rd}, {2'b10, 32'h0000_0000})
        wr(8'h24, 32'hFFFF_FFFF);
        `CHK(rs, 2'b10)
    endtask

    task automatic t_gate();
        flag_event_i <= 32'h0000_0020;
        @(posedge clock_i);
        flag_event_i <= 32'h0000_0000;
        rchk(OFS_PENDING, 32'h0000_0020);
        quiet(3);
        wr(OFS_ENABLE, 32'h0000_0010);
        quiet(3);
        wr(OFS_ENABLE, 32'h0000_0090);
        call(16'h0023, 2'b01);
        rchk(OFS_PENDING, 32'h0000_0020);
        wr(OFS_PENDING, 32'h0000_0000);
        cpu_model_i.ret();
        `CHK(in_service_o, 2'b00)
    endtask

    task automatic t_lat();
        wr(OFS_ENABLE, 32'h0000_0082);
        flag_event_i <= 32'h0000_0002;
        cpu_model_i.step(4);
        flag_event_i <= 32'h0000_0000;
        `CHK({long_call_req_o, long_call_vector_o}, {1'b1, 16'h000B})
        repeat (8) @(posedge clock_i);
        rchk(OFS_PENDING, 32'h0000_0000);
        cpu_model_i.ret();
    endtask

    task automatic t_vec();
        logic [31:0] m;
        wr(OFS_ENABLE, 32'h0000_00FF);
        wr(OFS_EXT_EN1, 32'h0000_00FF);
        wr(OFS_EXT_EN2, 32'h0000_000F);
        for (int s = 0; s < NUM_SRC; s++) begin
            m = SRC_MASK[s];
            m = m & ~(m - 32'h1);
            cpu_model_i.ack_wait = s % 3;
            if (s == 0) ext_irq_pin_0_i <= 1'b0;
            else if (s == 2) ext_irq_pin_1_i <= 1'b0;
            else if (s == 15) supply_warn_i <= 1'b1;
            else if (s == 16) port_match_i <= 1'b1;
            else wr(OFS_PENDING, m);
            call(16'h0003 + 16'(s * 8), 2'b01);
            wr(OFS_PENDING, 32'h0000_0000);
            if (s == 15) rchk(OFS_PENDING, m);
            ext_irq_pin_0_i <= 1'b1;
            ext_irq_pin_1_i <= 1'b1;
            supply_warn_i   <= 1'b0;
            port_match_i    <= 1'b0;
            @(posedge clock_i);
            cpu_model_i.ret();
        end
        cpu_model_i.ack_wait = 0;
    endtask

    task automatic t_prio();
        wr(OFS_PRIORITY, 32'h0000_0020);
        wr(OFS_PENDING, 32'h0000_0150);
        call(16'h002B, 2'b10);
        quiet(3);
        wr(OFS_PENDING, 32'h0000_0110);
        cpu_model_i.ret();
        repeat (4) @(posedge clock_i);
        `CHK({long_call_req_o, in_service_o}, 3'b000)
        call(16'h0023, 2'b01);
        wr(OFS_PRIORITY, 32'h0000_0060);
        call(16'h0033, 2'b11);
        wr(OFS_PENDING, 32'h0000_0010);
        cpu_model_i.ret();
        `CHK(in_service_o, 2'b01)
        wr(OFS_PENDING, 32'h0000_1010);
        quiet(3);
        wr(OFS_PENDING, 32'h0000_1000);
        cpu_model_i.ret();
        call(16'h003B, 2'b01);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        `CHK({long_call_req_o, in_service_o}, 3'b000)
        rchk(OFS_PRIORITY, 32'h0000_0080);
        rchk(OFS_PENDING, 32'h0000_0000);
    endtask

    initial begin
        resetn_i        = 1'b0;
        axil_req_i      = '0;
        flag_event_i    = '0;
        ext_irq_pin_0_i = 1'b1;
        ext_irq_pin_1_i = 1'b1;
        supply_warn_i   = 1'b0;
        port_match_i    = 1'b0;
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        t_regs();
        t_gate();
        t_lat();
        t_vec();
        t_prio();
        summarize();
    end
endmodule // testbench

bind irq_handler irq_handler_props irq_handler_props_i (.clock_i, .resetn_i, .instr_done_i,
    .return_from_irq_done_i, .long_call_ack_i, .long_call_req_o, .long_call_vector_o, .in_service_o);
